// File: src/smcg_cfg.svh
// Offsets, field positions, reset values and timing counts of the sleep block
`ifndef SMCG_CFG_SVH
`define SMCG_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SMCG_OFF_SLEEP_CTRL 8'h00
`define SMCG_OFF_CORE_CTRL 8'h04
`define SMCG_OFF_IN_DISABLE 8'h08
`define SMCG_OFF_ANALOG_CTRL 8'h0C
`define SMCG_OFF_STATUS 8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SMCG_SLP_SE_BIT 0
`define SMCG_SLP_SM_LSB 1
`define SMCG_CORE_JTD_BIT 0
`define SMCG_CORE_AS2_BIT 1
`define SMCG_ANA_ADC_EN_BIT 0
`define SMCG_ANA_COMP_DIS_BIT 1
`define SMCG_ANA_COMP_REF_BIT 2
`define SMCG_ANA_ADC_REF_BIT 3

// ----------------------------------------------------------------------
// Reset values and brown-out fuse off code
// ----------------------------------------------------------------------
`define SMCG_RST_SLEEP_CTRL 4'h0
`define SMCG_RST_CORE_CTRL 2'h0
`define SMCG_RST_IN_DISABLE 16'h0000
`define SMCG_RST_ANALOG_CTRL 4'h0
`define SMCG_BOD_OFF_CODE 3'h7

// ----------------------------------------------------------------------
// Timing counts in hclk cycles
// ----------------------------------------------------------------------
`define SMCG_STARTUP_CYC 5'd16
`define SMCG_STBY_WAKE_CYC 5'd2
`define SMCG_HALT_CYC 5'd4

`endif

// File: src/smcg_pkg.sv
// Types shared by the sleep-mode clock gating block
package smcg_pkg;

  // Sleep mode select encodings
  typedef enum logic [2:0] {
    SMCG_IDLE    = 3'b000,
    SMCG_ADCNR   = 3'b001,
    SMCG_PWRDOWN = 3'b010,
    SMCG_PWRSAVE = 3'b011,
    SMCG_RSVD4   = 3'b100,
    SMCG_RSVD5   = 3'b101,
    SMCG_STANDBY = 3'b110,
    SMCG_RSVD7   = 3'b111
  } smcg_mode_e;

  // Core power sequencer states
  typedef enum logic [1:0] {
    SMCG_ST_RUN   = 2'b00,
    SMCG_ST_SLEEP = 2'b01,
    SMCG_ST_WAKE  = 2'b10,
    SMCG_ST_HALT  = 2'b11
  } smcg_state_e;

endpackage

// File: src/smcg_clk_gate.sv
// Glitch-free clock gate for one clock domain
`timescale 1ns/1ps
`default_nettype none

module smcg_clk_gate (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Enable request from the sequencer
  input wire logic en_req,
  // Gated clock and its enable
  output logic gclk,
  output logic en_q
);

  // Enable moves only while hclk is low, so no runt pulse escapes
  always_ff @(negedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q <= 1'b1;
    end else begin
      en_q <= en_req;
    end
  end

  assign gclk = hclk & en_q;

endmodule
`default_nettype wire

// File: src/smcg_top.sv
// Sleep-mode sequencer, clock gating and low-power control with AHB-Lite regs
`timescale 1ns/1ps
`default_nettype none
`include "smcg_cfg.svh"

//
// Contract
// - Mode codes: 000 idle, 001 ADC noise, 010/011 down/save, 110 standby.
// - Interrupt wake: halt four cycles after start-up, then run handler.
// - Standby only with code 110 and crystal clock; oscillator keeps running.
// - Standby resumes within six clock cycles of a wake event.
// - Each mode gates its own set of clock domains and oscillators.
// - Async clock, timer oscillator, timer-2 wake outside idle need the async select bit.
// - Deep modes wake only on lines 3..0 or level lines 7..4; TWI always.
// - Enabled ADC stays on in sleep; re-enable makes next conversion extended.
// - Comparator auto-off in sleep except idle and ADC noise modes.
// - Comparator on internal reference keeps reference on in all sleep modes.
// - Reference on only when brown-out, comparator or ADC needs it.
// - Fuse-enabled brown-out detector keeps running in every sleep mode.
// - Enabled watchdog keeps running in every sleep mode.
// - Input buffers off when I/O and ADC clocks stop, wake pins kept.
// - Digital input disable bits kill pin buffers in every mode.
// - Programmed debug fuse keeps main clock source on in sleep while the debug port is enabled.
// - Port disable bit or unprogrammed port fuse disables the debug port.
// - TDO undriven while port enabled and TAP not shifting.
module smcg_top
  import smcg_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Core side
  input wire logic sleep_instr,
  input wire logic adc_conv_start,
  input wire logic wdt_enable,
  output logic core_halt,
  output logic resume_pulse,
  // Wake request sources, already gated by their enables
  input wire logic [7:0] ext_irq_enable,
  input wire logic [7:0] ext_level_mode,
  input wire logic twi_addr_match,
  input wire logic timer2_irq,
  input wire logic spm_ready_irq,
  input wire logic adc_irq,
  input wire logic other_io_irq,
  // Pins and fuses
  input wire logic [7:0] external_irq_lines,
  input wire logic xtal_clock_opt,
  input wire logic onchip_debug_fuse,
  input wire logic debug_port_enable_fuse,
  input wire logic [2:0] brownout_level_fuses,
  // Debug port
  input wire logic tap_shifting,
  input wire logic tap_tdo_data,
  output logic tdo_o,
  output logic tdo_oe_n,
  output logic jtag_en,
  // Gated clocks and enables
  output logic core_clock,
  output logic program_memory_clock,
  output logic peripheral_clock,
  output logic converter_clock,
  output logic async_timer_clock,
  output logic [4:0] domain_clk_en,
  output logic main_osc_en,
  output logic timer_osc_en,
  // Analogue and supervisor controls
  output logic adc_en,
  output logic adc_extended_conv,
  output logic comp_en,
  output logic vref_en,
  output logic bod_en,
  output logic wdt_run,
  output logic input_buf_en,
  output logic [7:0] wake_buf_en,
  output logic [15:0] pin_dig_in_en
);

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  logic [13:0] pin_s1_q;
  logic [13:0] pin_s2_q;
  logic [7:0] irq_d_q;
  logic [7:0] irq_pin;
  logic xtal_opt;
  logic ocd_fuse;
  logic port_fuse;
  logic [2:0] bod_fuse;

  // Two flops before any logic reads a pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_q <= 14'h3fff;
      pin_s2_q <= 14'h3fff;
      irq_d_q <= 8'hff;
    end else begin
      pin_s1_q <= {brownout_level_fuses, debug_port_enable_fuse,
                   onchip_debug_fuse, xtal_clock_opt, external_irq_lines};
      pin_s2_q <= pin_s1_q;
      irq_d_q <= pin_s2_q[7:0];
    end
  end

  assign irq_pin = pin_s2_q[7:0];
  assign xtal_opt = pin_s2_q[8];
  assign ocd_fuse = pin_s2_q[9];
  assign port_fuse = pin_s2_q[10];
  assign bod_fuse = pin_s2_q[13:11];

  // --------------------------------------------------------------------
  // Register file over AHB-Lite
  // --------------------------------------------------------------------
  logic [3:0] sleep_ctrl_q;
  logic [1:0] core_ctrl_q;
  logic [15:0] in_dis_q;
  logic [3:0] ana_ctrl_q;
  logic wr_pend_q;
  logic rd_wait_q;
  logic [7:0] addr_q;
  logic addr_ph;
  logic [31:0] rd_mux;
  logic [31:0] status_word;
  smcg_state_e state_q;
  smcg_mode_e mode_q;

  assign addr_ph = hsel & htrans[1] & hready;
  assign hreadyout = ~rd_wait_q;
  assign hresp = 1'b0;

  // Address phase capture; reads take one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_wait_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ph & hwrite;
      rd_wait_q <= addr_ph & ~hwrite;
      if (addr_ph) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  // Writes land in the data phase; unmapped offsets are ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_ctrl_q <= `SMCG_RST_SLEEP_CTRL;
      core_ctrl_q <= `SMCG_RST_CORE_CTRL;
      in_dis_q <= `SMCG_RST_IN_DISABLE;
      ana_ctrl_q <= `SMCG_RST_ANALOG_CTRL;
    end else if (wr_pend_q) begin
      unique case (addr_q)
        `SMCG_OFF_SLEEP_CTRL: sleep_ctrl_q <= hwdata[3:0];
        `SMCG_OFF_CORE_CTRL: core_ctrl_q <= hwdata[1:0];
        `SMCG_OFF_IN_DISABLE: in_dis_q <= hwdata[15:0];
        `SMCG_OFF_ANALOG_CTRL: ana_ctrl_q <= hwdata[3:0];
        default: ;
      endcase
    end
  end

  assign status_word = {23'h00_0000, jtag_en, vref_en, comp_en, main_osc_en,
                        state_q, mode_q};

  // Read mux, zero for unmapped offsets
  always_comb begin
    unique case (addr_q)
      `SMCG_OFF_SLEEP_CTRL: rd_mux = {28'h000_0000, sleep_ctrl_q};
      `SMCG_OFF_CORE_CTRL: rd_mux = {30'h0000_0000, core_ctrl_q};
      `SMCG_OFF_IN_DISABLE: rd_mux = {16'h0000, in_dis_q};
      `SMCG_OFF_ANALOG_CTRL: rd_mux = {28'h000_0000, ana_ctrl_q};
      `SMCG_OFF_STATUS: rd_mux = status_word;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_wait_q) begin
      hrdata <= rd_mux;
    end
  end

  // --------------------------------------------------------------------
  // Sleep sequencer
  // --------------------------------------------------------------------
  logic sleep_en;
  logic as2;
  smcg_mode_e sm_sel;
  logic mode_ok;
  logic sleep_go;
  logic deep;
  logic [7:0] ext_req;
  logic [7:0] ext_wake_ok;
  logic wake_any;
  logic [4:0] cnt_q;

  assign sleep_en = sleep_ctrl_q[`SMCG_SLP_SE_BIT];
  assign sm_sel = smcg_mode_e'(sleep_ctrl_q[`SMCG_SLP_SM_LSB +: 3]);
  assign as2 = core_ctrl_q[`SMCG_CORE_AS2_BIT];

  // Reserved codes never sleep; standby needs a crystal clock
  always_comb begin
    unique case (sm_sel)
      SMCG_IDLE, SMCG_ADCNR, SMCG_PWRDOWN, SMCG_PWRSAVE: mode_ok = 1'b1;
      SMCG_STANDBY: mode_ok = xtal_opt;
      default: mode_ok = 1'b0;
    endcase
  end

  assign sleep_go = sleep_instr & sleep_en & mode_ok;
  assign deep = (mode_q != SMCG_IDLE);

  // Low level or any edge on an enabled line asks for wake-up
  assign ext_req = ext_irq_enable &
                   ((ext_level_mode & ~irq_pin) |
                    (~ext_level_mode & (irq_pin ^ irq_d_q)));
  // Deep modes: lines 3..0 any kind, lines 7..4 level only
  assign ext_wake_ok = deep ? (ext_req & {ext_level_mode[7:4], 4'hf})
                            : ext_req;

  // Wake sources per mode
  always_comb begin
    wake_any = (|ext_wake_ok) | twi_addr_match;
    unique case (mode_q)
      SMCG_IDLE: wake_any = wake_any | timer2_irq | spm_ready_irq | adc_irq |
                            other_io_irq;
      SMCG_ADCNR: wake_any = wake_any | (timer2_irq & as2) | spm_ready_irq |
                             adc_irq;
      SMCG_PWRSAVE: wake_any = wake_any | (timer2_irq & as2);
      default: wake_any = wake_any;
    endcase
  end

  // State and mode latched at entry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= SMCG_ST_RUN;
      mode_q <= SMCG_IDLE;
      cnt_q <= 5'd0;
    end else begin
      unique case (state_q)
        SMCG_ST_RUN: if (sleep_go) begin
          state_q <= SMCG_ST_SLEEP;
          mode_q <= sm_sel;
        end
        SMCG_ST_SLEEP: if (wake_any) begin
          state_q <= SMCG_ST_WAKE;
          // Standby keeps the oscillator, so only a short restart
          cnt_q <= (mode_q == SMCG_STANDBY) ? `SMCG_STBY_WAKE_CYC - 5'd1
                                            : `SMCG_STARTUP_CYC - 5'd1;
        end
        SMCG_ST_WAKE: if (cnt_q == 5'd0) begin
          state_q <= SMCG_ST_HALT;
          cnt_q <= `SMCG_HALT_CYC - 5'd1;
        end else begin
          cnt_q <= cnt_q - 5'd1;
        end
        SMCG_ST_HALT: if (cnt_q == 5'd0) begin
          state_q <= SMCG_ST_RUN;
        end else begin
          cnt_q <= cnt_q - 5'd1;
        end
      endcase
    end
  end

  assign core_halt = (state_q != SMCG_ST_RUN);
  assign resume_pulse = (state_q == SMCG_ST_HALT) && (cnt_q == 5'd0);

  // --------------------------------------------------------------------
  // Clock domain requests and gates
  // --------------------------------------------------------------------
  logic asleep;
  logic [4:0] dom_req;
  logic dbg_force;

  assign asleep = (state_q == SMCG_ST_SLEEP);
  assign jtag_en = port_fuse & ~core_ctrl_q[`SMCG_CORE_JTD_BIT];
  assign dbg_force = ocd_fuse & jtag_en;

  // Order: cpu, flash, io, adc, async; cpu runs again in the halt window
  always_comb begin
    dom_req = {as2, 4'hf};
    main_osc_en = 1'b1;
    timer_osc_en = as2;
    if (state_q == SMCG_ST_WAKE) begin
      dom_req = {as2, 4'hc};
    end else if (asleep) begin
      unique case (mode_q)
        SMCG_IDLE: dom_req = {as2, 4'hc};
        SMCG_ADCNR: dom_req = {as2, 4'h8};
        SMCG_PWRSAVE: begin
          dom_req = {as2, 4'h0};
          main_osc_en = 1'b0;
        end
        SMCG_STANDBY: dom_req = 5'h00;
        default: begin
          dom_req = 5'h00;
          main_osc_en = 1'b0;
          timer_osc_en = 1'b0;
        end
      endcase
      main_osc_en = main_osc_en | dbg_force;
    end
  end

  // One gate per domain, enable changes while the clock is low
  smcg_clk_gate u_gate_cpu (.hclk(hclk), .hresetn(hresetn),
    .en_req(dom_req[0]), .gclk(core_clock), .en_q(domain_clk_en[0]));
  smcg_clk_gate u_gate_flash (.hclk(hclk), .hresetn(hresetn),
    .en_req(dom_req[1]), .gclk(program_memory_clock),
    .en_q(domain_clk_en[1]));
  smcg_clk_gate u_gate_io (.hclk(hclk), .hresetn(hresetn),
    .en_req(dom_req[2]), .gclk(peripheral_clock), .en_q(domain_clk_en[2]));
  smcg_clk_gate u_gate_adc (.hclk(hclk), .hresetn(hresetn),
    .en_req(dom_req[3]), .gclk(converter_clock), .en_q(domain_clk_en[3]));
  smcg_clk_gate u_gate_asy (.hclk(hclk), .hresetn(hresetn),
    .en_req(dom_req[4]), .gclk(async_timer_clock), .en_q(domain_clk_en[4]));

  // --------------------------------------------------------------------
  // Analogue, supervisor and pin controls
  // --------------------------------------------------------------------
  logic adc_on;
  logic comp_on_req;
  logic comp_ref;
  logic bufs_off;
  logic adc_prev_q;

  assign adc_on = ana_ctrl_q[`SMCG_ANA_ADC_EN_BIT];
  assign comp_on_req = ~ana_ctrl_q[`SMCG_ANA_COMP_DIS_BIT];
  assign comp_ref = comp_on_req & ana_ctrl_q[`SMCG_ANA_COMP_REF_BIT];
  // Input buffers are off only where both io and adc clocks stop
  assign bufs_off = asleep & (mode_q != SMCG_IDLE) & (mode_q != SMCG_ADCNR);

  // Registered controls; sleep never touches the ADC, BOD or watchdog
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_en <= 1'b0;
      comp_en <= 1'b0;
      vref_en <= 1'b0;
      bod_en <= 1'b0;
      wdt_run <= 1'b0;
      input_buf_en <= 1'b1;
      wake_buf_en <= 8'hff;
      pin_dig_in_en <= 16'hffff;
    end else begin
      adc_en <= adc_on;
      comp_en <= comp_on_req & (~bufs_off);
      vref_en <= (bod_fuse != `SMCG_BOD_OFF_CODE) | comp_ref |
                 (adc_on & ana_ctrl_q[`SMCG_ANA_ADC_REF_BIT]);
      bod_en <= (bod_fuse != `SMCG_BOD_OFF_CODE);
      wdt_run <= wdt_enable;
      input_buf_en <= ~bufs_off;
      wake_buf_en <= bufs_off ? (ext_irq_enable &
                                 {ext_level_mode[7:4], 4'hf}) : 8'hff;
      pin_dig_in_en <= ~in_dis_q & {16{~bufs_off}};
    end
  end

  // Off-then-on of the ADC arms an extended conversion; set beats clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_prev_q <= 1'b0;
      adc_extended_conv <= 1'b1;
    end else begin
      adc_prev_q <= adc_on;
      if (adc_on & ~adc_prev_q) begin
        adc_extended_conv <= 1'b1;
      end else if (adc_conv_start) begin
        adc_extended_conv <= 1'b0;
      end
    end
  end

  // TDO released unless the port is enabled and shifting; board pull-up holds it high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tdo_o <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else begin
      tdo_o <= tap_tdo_data;
      tdo_oe_n <= ~(jtag_en & tap_shifting);
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  sequence s_halt_window;
    (state_q == SMCG_ST_HALT) [*4] ##1 (state_q == SMCG_ST_RUN);
  endsequence

  property p_reserved_no_sleep;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == SMCG_ST_RUN && sleep_instr && !mode_ok) |=>
      (state_q == SMCG_ST_RUN);
  endproperty
  a_reserved_no_sleep: assert property (p_reserved_no_sleep)
    else $error("sleep entered on reserved or disallowed mode");

  property p_halt_four;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == SMCG_ST_WAKE && cnt_q == 5'd0) |=> s_halt_window;
  endproperty
  a_halt_four: assert property (p_halt_four)
    else $error("halt window is not four cycles");

  property p_standby_xtal;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == SMCG_ST_SLEEP && mode_q == SMCG_STANDBY) |->
      $past(xtal_opt);
  endproperty
  a_standby_xtal: assert property (p_standby_xtal)
    else $error("standby without crystal clock option");

  property p_standby_six;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == SMCG_ST_SLEEP && mode_q == SMCG_STANDBY && wake_any) |->
      ##6 resume_pulse;
  endproperty
  a_standby_six: assert property (p_standby_six)
    else $error("standby wake took other than six cycles");

  property p_idle_gating;
    @(posedge hclk) disable iff (!hresetn)
    (asleep && mode_q == SMCG_IDLE) |=>
      (!domain_clk_en[0] && !domain_clk_en[1] && domain_clk_en[2]);
  endproperty
  a_idle_gating: assert property (p_idle_gating)
    else $error("idle mode gated the wrong domains");

  property p_comp_auto_off;
    @(posedge hclk) disable iff (!hresetn)
    (asleep && mode_q == SMCG_PWRDOWN) ##1 asleep |-> !comp_en;
  endproperty
  a_comp_auto_off: assert property (p_comp_auto_off)
    else $error("comparator left on in deep sleep");

  property p_vref_comp;
    @(posedge hclk) disable iff (!hresetn)
    comp_ref |=> vref_en;
  endproperty
  a_vref_comp: assert property (p_vref_comp)
    else $error("reference dropped while comparator uses it");

  property p_tdo_float;
    @(posedge hclk) disable iff (!hresetn)
    !(jtag_en && tap_shifting) |=> tdo_oe_n;
  endproperty
  a_tdo_float: assert property (p_tdo_float)
    else $error("TDO driven while not shifting");

endmodule
`default_nettype wire

// File: sim/smcg_tb_top.sv
// Self-checking bench for the sleep-mode clock gating block
`timescale 1ns/1ps
`default_nettype none
`include "smcg_cfg.svh"

module smcg_tb_top
  import smcg_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and design under test
  // ----------------------------------------------------------------
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic sleep_instr, wdt_enable, core_halt, resume_pulse;
  logic [7:0] ext_irq_enable, ext_level_mode, external_irq_lines;
  logic twi_addr_match, other_io_irq, timer2_irq, xtal_clock_opt;
  logic onchip_debug_fuse, debug_port_enable_fuse, tap_shifting;
  logic [2:0] brownout_level_fuses;
  logic tdo_oe_n, jtag_en, main_osc_en, comp_en, bod_en, wdt_run;
  logic input_buf_en;
  logic [15:0] pin_dig_in_en;
  logic adc_conv_start, adc_en, adc_extended_conv, vref_en;
  logic [4:0] domain_clk_en;
  int failures, comparisons, cyc, n;

  smcg_top uut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'd2),
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .sleep_instr,
    .adc_conv_start, .wdt_enable, .core_halt, .resume_pulse,
    .ext_irq_enable, .ext_level_mode, .twi_addr_match, .timer2_irq,
    .spm_ready_irq(1'b0), .adc_irq(1'b0), .other_io_irq,
    .external_irq_lines, .xtal_clock_opt, .onchip_debug_fuse,
    .debug_port_enable_fuse, .brownout_level_fuses, .tap_shifting,
    .tap_tdo_data(1'b0), .tdo_o(), .tdo_oe_n, .jtag_en, .core_clock(),
    .program_memory_clock(), .peripheral_clock(), .converter_clock(),
    .async_timer_clock(), .domain_clk_en, .main_osc_en,
    .timer_osc_en(), .adc_en, .adc_extended_conv, .comp_en,
    .vref_en, .bod_en, .wdt_run, .input_buf_en, .wake_buf_en(),
    .pin_dig_in_en
  );
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Verdict and end of run
  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Wait k edges, then let that edge's updates land
  task automatic step(input int k);
    repeat (k) @(posedge hclk);
    #1;
  endtask

  // One AHB-Lite single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [31:0] a, d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Select a mode with sleep enabled, then issue the sleep instruction
  task automatic go_sleep(input logic [2:0] m);
    bus(1'b1, `SMCG_OFF_SLEEP_CTRL, {28'h000_0000, m, 1'b1});
    @(posedge hclk);
    sleep_instr <= 1'b1;
    @(posedge hclk);
    sleep_instr <= 1'b0;
    step(2);
  endtask

  // Count edges until the handler dispatch pulse; bounded
  task automatic wait_resume();
    n = 0;
    while (resume_pulse !== 1'b1 && n < 40) begin
      @(posedge hclk);
      n++;
    end
  endtask

  // Wake by two-wire address match, which every mode accepts
  task automatic twi_wake();
    @(posedge hclk);
    twi_addr_match <= 1'b1;
    wait_resume();
    twi_addr_match <= 1'b0;
    step(1);
  endtask

  // ----------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------
  // 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Cut a hang short; the whole run needs well under this
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end

  initial begin
    {hresetn, hsel, hwrite, sleep_instr, tap_shifting} = 5'b0;
    {haddr, hwdata, htrans} = '0;
    {twi_addr_match, other_io_irq, timer2_irq, adc_conv_start} = 4'h0;
    {ext_irq_enable, ext_level_mode} = {8'h21, 8'h00};
    external_irq_lines = 8'hff;
    {xtal_clock_opt, debug_port_enable_fuse, wdt_enable} = 3'b111;
    onchip_debug_fuse = 1'b0;
    brownout_level_fuses = 3'b011;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    step(4);
    // Reset values, then an unmapped place that keeps nothing
    check(pin_dig_in_en, 16'hffff);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 32'(4 * i), '0);
      check(rd, 32'h0000_0000);
      check(hresp, 1'b0);
    end
    bus(1'b1, 32'h0000_0020, 32'hffff_ffff);
    bus(1'b0, 32'h0000_0020, '0);
    check(rd, 32'h0000_0000);
    bus(1'b1, `SMCG_OFF_IN_DISABLE, 32'h0000_8001);
    step(2);
    check(pin_dig_in_en, 16'h7ffe);
    check(bod_en, 1'b1);
    check(jtag_en, 1'b1);
    check(tdo_oe_n, 1'b1);
    @(posedge hclk);
    tap_shifting <= 1'b1;
    step(3);
    check(tdo_oe_n, 1'b0);
    // Idle keeps the oscillator and comparator; other I/O wakes it
    go_sleep(SMCG_IDLE);
    check(core_halt, 1'b1);
    check({main_osc_en, comp_en, input_buf_en}, 3'b111);
    @(posedge hclk);
    other_io_irq <= 1'b1;
    wait_resume();
    other_io_irq <= 1'b0;
    check(n, 32'd21);
    step(1);
    check(core_halt, 1'b0);
    // Power-down: clocks, comparator and buffers off, supervisors on
    go_sleep(SMCG_PWRDOWN);
    check({main_osc_en, comp_en}, 2'b00);
    check(input_buf_en, 1'b0);
    check({bod_en, wdt_run}, 2'b11);
    @(posedge hclk);
    external_irq_lines <= 8'hdf;
    other_io_irq <= 1'b1;
    step(8);
    check(core_halt, 1'b1);
    @(posedge hclk);
    other_io_irq <= 1'b0;
    external_irq_lines <= 8'hde;
    wait_resume();
    check(resume_pulse, 1'b1);
    step(2);
    // Standby keeps the oscillator and wakes fast
    go_sleep(SMCG_STANDBY);
    check({core_halt, main_osc_en}, 2'b11);
    twi_wake();
    check(n, 32'd7);
    // Reserved codes and standby without a crystal do not sleep
    go_sleep(SMCG_RSVD4);
    check(core_halt, 1'b0);
    go_sleep(SMCG_RSVD5);
    check(core_halt, 1'b0);
    go_sleep(SMCG_RSVD7);
    check(core_halt, 1'b0);
    @(posedge hclk);
    xtal_clock_opt <= 1'b0;
    step(4);
    go_sleep(SMCG_STANDBY);
    check(core_halt, 1'b0);
    // Debug fuse forces the oscillator on until the port is disabled
    @(posedge hclk);
    onchip_debug_fuse <= 1'b1;
    step(4);
    go_sleep(SMCG_PWRDOWN);
    check(main_osc_en, 1'b1);
    twi_wake();
    bus(1'b1, `SMCG_OFF_CORE_CTRL, 32'h0000_0001);
    step(2);
    check(jtag_en, 1'b0);
    check(tdo_oe_n, 1'b1);
    go_sleep(SMCG_PWRDOWN);
    check(main_osc_en, 1'b0);
    twi_wake();
    // Power-save runs the async domain only with async select set
    bus(1'b1, `SMCG_OFF_CORE_CTRL, 32'h0000_0003);
    go_sleep(SMCG_PWRSAVE);
    check({domain_clk_en, main_osc_en}, 6'b10_0000);
    @(posedge hclk);
    timer2_irq <= 1'b1;
    wait_resume();
    timer2_irq <= 1'b0;
    check(n, 32'd21);
    step(1);
    // ADC noise without async select: timer 2 ignored, buffers kept on
    bus(1'b1, `SMCG_OFF_CORE_CTRL, 32'h0000_0001);
    go_sleep(SMCG_ADCNR);
    check({domain_clk_en, input_buf_en}, 6'b01_0001);
    @(posedge hclk);
    timer2_irq <= 1'b1;
    step(8);
    check(core_halt, 1'b1);
    @(posedge hclk);
    timer2_irq <= 1'b0;
    twi_wake();
    // Reference follows its users; ADC off then on arms an extended run
    @(posedge hclk);
    brownout_level_fuses <= 3'b111;
    step(4);
    check({bod_en, vref_en}, 2'b00);
    bus(1'b1, `SMCG_OFF_ANALOG_CTRL, 32'h0000_0005);
    @(posedge hclk);
    adc_conv_start <= 1'b1;
    @(posedge hclk);
    adc_conv_start <= 1'b0;
    step(1);
    check({adc_en, vref_en, adc_extended_conv}, 3'b110);
    go_sleep(SMCG_PWRDOWN);
    check({adc_en, vref_en, comp_en}, 3'b110);
    twi_wake();
    bus(1'b1, `SMCG_OFF_ANALOG_CTRL, 32'h0000_0000);
    bus(1'b1, `SMCG_OFF_ANALOG_CTRL, 32'h0000_0001);
    step(2);
    check({adc_extended_conv, vref_en}, 2'b10);
    results();
  end

endmodule
`default_nettype wire
